/* shared/mbd_pkg.sv */
// Constants and types shared by the instruction decode and timing block
package mbd_pkg;
  // Clock and instruction cycle timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam logic [2:0] CLKS_PER_ICYC = 3'h4;
  // Special function register addresses
  localparam logic [7:0] SFR_STRETCH = 8'h8E;
  localparam logic [7:0] SFR_PTR_SEL = 8'h86;
  localparam logic [7:0] STRETCH_RESET = 8'h01;
  localparam logic [7:0] PTR_SEL_RESET = 8'h00;
  localparam int unsigned STRETCH_LSB = 0;
  localparam int unsigned PTR_SEL_BIT = 0;
  localparam logic [3:0] XDATA_BASE_CYC = 4'h2;
  // Opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_NOP_RSVD = 8'hA5;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_SET_C = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_AND_C_BIT = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT = 8'hB0;
  localparam logic [7:0] OP_OR_C_BIT = 8'h72;
  localparam logic [7:0] OP_OR_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_LOAD_PTR = 8'h90;
  localparam logic [7:0] OP_CODE_RD_PTR = 8'h93;
  localparam logic [7:0] OP_CODE_RD_PC = 8'h83;
  localparam logic [7:0] OP_XRD_PTR = 8'hE0;
  localparam logic [7:0] OP_XWR_PTR = 8'hF0;
  localparam logic [6:0] OP_XRD_IND = 7'h71;
  localparam logic [6:0] OP_XWR_IND = 7'h79;
  localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
  localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_POP = 8'hD0;
  localparam logic [4:0] OP_XCH_REG = 5'h19;
  localparam logic [6:0] OP_XCH_IND = 7'h63;
  localparam logic [6:0] OP_NIBBLE_XCH = 7'h6B;
  localparam logic [4:0] OP_PAGE_JUMP_LO = 5'h01;
  localparam logic [4:0] OP_PAGE_CALL_LO = 5'h11;
  localparam logic [7:0] OP_FAR_CALL = 8'h12;
  localparam logic [7:0] OP_FAR_JUMP = 8'h02;
  localparam logic [7:0] OP_RETURN = 8'h22;
  localparam logic [7:0] OP_INT_RETURN = 8'h32;
  localparam logic [7:0] OP_NEAR_JUMP = 8'h80;
  localparam logic [7:0] OP_JUMP_C = 8'h40;
  localparam logic [7:0] OP_JUMP_NC = 8'h50;
  localparam logic [7:0] OP_JUMP_BIT = 8'h20;
  localparam logic [7:0] OP_JUMP_NBIT = 8'h30;
  localparam logic [7:0] OP_JUMP_BIT_CLR = 8'h10;
  localparam logic [7:0] OP_JUMP_IND = 8'h73;
  localparam logic [7:0] OP_JUMP_Z = 8'h60;
  localparam logic [7:0] OP_JUMP_NZ = 8'h70;
  localparam logic [7:0] OP_CMP_A_DIR = 8'hB5;
  localparam logic [7:0] OP_CMP_A_IMM = 8'hB4;
  localparam logic [4:0] OP_CMP_REG = 5'h17;
  localparam logic [6:0] OP_CMP_IND = 7'h5B;
  localparam logic [4:0] OP_DEC_REG = 5'h1B;
  localparam logic [7:0] OP_DEC_DIR = 8'hD5;
  // Instruction classes
  typedef enum logic [2:0] {
    MBD_CLS_OTHER = 3'b000,
    MBD_CLS_BOOL = 3'b001,
    MBD_CLS_MOVE = 3'b010,
    MBD_CLS_XDATA = 3'b011,
    MBD_CLS_BRANCH = 3'b100,
    MBD_CLS_NOP = 3'b101
  } mbd_class_t;
  typedef enum logic [1:0] {
    MBD_ST_FETCH = 2'b00,
    MBD_ST_OPER = 2'b01,
    MBD_ST_EXEC = 2'b10
  } mbd_state_t;
endpackage

/* design/mbd_decode.sv */
// Instruction decode, fetch sequencing and cycle timing for the bit, move and branch groups
`timescale 1ns/1ns
`default_nettype none

module mbd_decode (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_code_data,
  input wire logic i_code_valid,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_code_req,
  output logic [7:0] o_opcode,
  output logic [1:0] o_len_bytes,
  output logic [3:0] o_len_cycles,
  output logic [2:0] o_class,
  output logic o_use_ptr1,
  output logic o_xdata_wr,
  output logic o_busy,
  output logic o_instr_done
);

  // ===========================================
  // Decode functions
  function automatic logic [1:0] f_len(input logic [7:0] op);
    logic [1:0] n;
    n = 2'h1;
    if (op == mbd_pkg::OP_CLR_BIT || op == mbd_pkg::OP_SET_BIT ||
        op == mbd_pkg::OP_CPL_BIT) n = 2'h2;
    if (op == mbd_pkg::OP_AND_C_BIT || op == mbd_pkg::OP_AND_C_NBIT) n = 2'h2;
    if (op == mbd_pkg::OP_OR_C_BIT || op == mbd_pkg::OP_OR_C_NBIT) n = 2'h2;
    if (op == mbd_pkg::OP_MOV_C_BIT || op == mbd_pkg::OP_MOV_BIT_C) n = 2'h2;
    if (op == mbd_pkg::OP_LOAD_PTR) n = 2'h3;
    if (op == mbd_pkg::OP_MOV_DIR_DIR) n = 2'h3;
    if (op == mbd_pkg::OP_MOV_DIR_IMM) n = 2'h3;
    if (op == mbd_pkg::OP_PUSH || op == mbd_pkg::OP_POP) n = 2'h2;
    if (op[4:0] == mbd_pkg::OP_PAGE_JUMP_LO || op[4:0] == mbd_pkg::OP_PAGE_CALL_LO) n = 2'h2;
    if (op == mbd_pkg::OP_FAR_CALL || op == mbd_pkg::OP_FAR_JUMP) n = 2'h3;
    if (op == mbd_pkg::OP_NEAR_JUMP || op == mbd_pkg::OP_JUMP_C ||
        op == mbd_pkg::OP_JUMP_NC) n = 2'h2;
    if (op == mbd_pkg::OP_JUMP_BIT || op == mbd_pkg::OP_JUMP_NBIT ||
        op == mbd_pkg::OP_JUMP_BIT_CLR) n = 2'h3;
    if (op == mbd_pkg::OP_JUMP_Z || op == mbd_pkg::OP_JUMP_NZ) n = 2'h2;
    if (op == mbd_pkg::OP_CMP_A_DIR || op == mbd_pkg::OP_CMP_A_IMM ||
        op[7:3] == mbd_pkg::OP_CMP_REG || op[7:1] == mbd_pkg::OP_CMP_IND) n = 2'h3;
    if (op[7:3] == mbd_pkg::OP_DEC_REG) n = 2'h2;
    if (op == mbd_pkg::OP_DEC_DIR) n = 2'h3;
    return n;
  endfunction

  function automatic logic f_is_xdata(input logic [7:0] op);
    return op == mbd_pkg::OP_XRD_PTR || op == mbd_pkg::OP_XWR_PTR ||
           op[7:1] == mbd_pkg::OP_XRD_IND || op[7:1] == mbd_pkg::OP_XWR_IND;
  endfunction

  function automatic logic [3:0] f_cycles(input logic [7:0] op, input logic [2:0] stretch);
    logic [3:0] c;
    c = {2'h0, f_len(op)};
    if (op == mbd_pkg::OP_CODE_RD_PTR || op == mbd_pkg::OP_CODE_RD_PC) c = 4'h3;
    if (op[4:0] == mbd_pkg::OP_PAGE_JUMP_LO || op[4:0] == mbd_pkg::OP_PAGE_CALL_LO) c = 4'h3;
    if (op == mbd_pkg::OP_FAR_CALL || op == mbd_pkg::OP_FAR_JUMP) c = 4'h4;
    if (op == mbd_pkg::OP_RETURN || op == mbd_pkg::OP_INT_RETURN) c = 4'h4;
    if (op == mbd_pkg::OP_NEAR_JUMP || op == mbd_pkg::OP_JUMP_C ||
        op == mbd_pkg::OP_JUMP_NC) c = 4'h3;
    if (op == mbd_pkg::OP_JUMP_BIT || op == mbd_pkg::OP_JUMP_NBIT ||
        op == mbd_pkg::OP_JUMP_BIT_CLR) c = 4'h4;
    if (op == mbd_pkg::OP_JUMP_IND) c = 4'h3;
    if (op == mbd_pkg::OP_JUMP_Z || op == mbd_pkg::OP_JUMP_NZ) c = 4'h3;
    if (op == mbd_pkg::OP_CMP_A_DIR || op == mbd_pkg::OP_CMP_A_IMM ||
        op[7:3] == mbd_pkg::OP_CMP_REG || op[7:1] == mbd_pkg::OP_CMP_IND) c = 4'h4;
    if (op[7:3] == mbd_pkg::OP_DEC_REG) c = 4'h3;
    if (op == mbd_pkg::OP_DEC_DIR) c = 4'h4;
    if (f_is_xdata(op)) c = mbd_pkg::XDATA_BASE_CYC + {1'b0, stretch};
    return c;
  endfunction

  function automatic mbd_pkg::mbd_class_t f_class(input logic [7:0] op);
    mbd_pkg::mbd_class_t k;
    k = mbd_pkg::MBD_CLS_OTHER;
    if (op == mbd_pkg::OP_NOP || op == mbd_pkg::OP_NOP_RSVD) k = mbd_pkg::MBD_CLS_NOP;
    else if (f_is_xdata(op)) k = mbd_pkg::MBD_CLS_XDATA;
    else if (op[7:3] == mbd_pkg::OP_XCH_REG || op[7:1] == mbd_pkg::OP_XCH_IND ||
             op[7:1] == mbd_pkg::OP_NIBBLE_XCH) k = mbd_pkg::MBD_CLS_MOVE;
    else if (op[4:0] == mbd_pkg::OP_PAGE_JUMP_LO || op[4:0] == mbd_pkg::OP_PAGE_CALL_LO ||
             op == mbd_pkg::OP_FAR_CALL || op == mbd_pkg::OP_FAR_JUMP ||
             op == mbd_pkg::OP_RETURN || op == mbd_pkg::OP_INT_RETURN ||
             op == mbd_pkg::OP_NEAR_JUMP || op == mbd_pkg::OP_JUMP_C ||
             op == mbd_pkg::OP_JUMP_NC || op == mbd_pkg::OP_JUMP_BIT ||
             op == mbd_pkg::OP_JUMP_NBIT || op == mbd_pkg::OP_JUMP_BIT_CLR ||
             op == mbd_pkg::OP_JUMP_IND || op == mbd_pkg::OP_JUMP_Z ||
             op == mbd_pkg::OP_JUMP_NZ || op == mbd_pkg::OP_CMP_A_DIR ||
             op == mbd_pkg::OP_CMP_A_IMM || op[7:3] == mbd_pkg::OP_CMP_REG ||
             op[7:1] == mbd_pkg::OP_CMP_IND || op[7:3] == mbd_pkg::OP_DEC_REG ||
             op == mbd_pkg::OP_DEC_DIR) k = mbd_pkg::MBD_CLS_BRANCH;
    return k;
  endfunction

  // ===========================================
  // Special function registers
  logic [7:0] stretch_r;
  logic ptr_sel_r;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      stretch_r <= mbd_pkg::STRETCH_RESET;
    end else if (i_sfr_wr && i_sfr_addr == mbd_pkg::SFR_STRETCH) begin
      stretch_r <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ptr_sel_r <= mbd_pkg::PTR_SEL_RESET[0];
    end else if (i_sfr_wr && i_sfr_addr == mbd_pkg::SFR_PTR_SEL) begin
      ptr_sel_r <= i_sfr_wdata[mbd_pkg::PTR_SEL_BIT];
    end
  end

  // Read data registered so the output stays flop driven; unused select bits read zero
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_addr == mbd_pkg::SFR_STRETCH) begin
      o_sfr_rdata <= stretch_r;
    end else if (i_sfr_addr == mbd_pkg::SFR_PTR_SEL) begin
      o_sfr_rdata <= {7'h00, ptr_sel_r};
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  // ===========================================
  // Fetch and execute sequencer
  mbd_pkg::mbd_state_t state_r;
  logic [1:0] clk_cnt_r;
  logic [1:0] bytes_left_r;
  logic [3:0] cyc_left_r;
  logic icyc_end;

  assign icyc_end = clk_cnt_r == 2'(mbd_pkg::CLKS_PER_ICYC - 3'h1);

  // Clock divider free runs so every instruction cycle is exactly four clocks
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      clk_cnt_r <= 2'h0;
    end else begin
      clk_cnt_r <= clk_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_r <= mbd_pkg::MBD_ST_FETCH;
      bytes_left_r <= 2'h0;
      cyc_left_r <= 4'h0;
      o_opcode <= 8'h00;
      o_len_bytes <= 2'h0;
      o_len_cycles <= 4'h0;
      o_class <= 3'b000;
      o_use_ptr1 <= 1'b0;
      o_xdata_wr <= 1'b0;
    end else begin
      case (state_r)
        mbd_pkg::MBD_ST_FETCH: begin
          if (i_code_valid && o_code_req) begin
            o_opcode <= i_code_data;
            o_len_bytes <= f_len(i_code_data);
            o_len_cycles <= f_cycles(i_code_data, stretch_r[2:0]);
            o_class <= f_class(i_code_data);
            o_use_ptr1 <= ptr_sel_r;
            o_xdata_wr <= i_code_data == mbd_pkg::OP_XWR_PTR ||
                          i_code_data[7:1] == mbd_pkg::OP_XWR_IND;
            bytes_left_r <= f_len(i_code_data) - 2'h1;
            cyc_left_r <= f_cycles(i_code_data, stretch_r[2:0]);
            state_r <= (f_len(i_code_data) > 2'h1) ? mbd_pkg::MBD_ST_OPER
                                                   : mbd_pkg::MBD_ST_EXEC;
          end
        end
        mbd_pkg::MBD_ST_OPER: begin
          if (icyc_end && cyc_left_r != 4'h0) begin
            cyc_left_r <= cyc_left_r - 4'h1;
          end
          if (i_code_valid && o_code_req) begin
            bytes_left_r <= bytes_left_r - 2'h1;
            if (bytes_left_r == 2'h1) state_r <= mbd_pkg::MBD_ST_EXEC;
          end
        end
        mbd_pkg::MBD_ST_EXEC: begin
          if (icyc_end) begin
            if (cyc_left_r <= 4'h1) begin
              cyc_left_r <= 4'h0;
              state_r <= mbd_pkg::MBD_ST_FETCH;
            end else begin
              cyc_left_r <= cyc_left_r - 4'h1;
            end
          end
        end
        default: state_r <= mbd_pkg::MBD_ST_FETCH;
      endcase
    end
  end

  // Code request held while bytes are still owed; dropped on the accepting edge
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_code_req <= 1'b0;
    end else if (i_code_valid && o_code_req) begin
      o_code_req <= state_r == mbd_pkg::MBD_ST_OPER ? bytes_left_r > 2'h1
                                                     : f_len(i_code_data) > 2'h1;
    end else begin
      o_code_req <= state_r == mbd_pkg::MBD_ST_FETCH ||
                    (state_r == mbd_pkg::MBD_ST_OPER && bytes_left_r != 2'h0);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_instr_done <= 1'b0;
    end else begin
      o_busy <= state_r != mbd_pkg::MBD_ST_FETCH;
      o_instr_done <= state_r == mbd_pkg::MBD_ST_EXEC && icyc_end && cyc_left_r <= 4'h1;
    end
  end

  // ===========================================
  // Checks
  // Opcode accept strobe shared by the checks from chk_bit_len to chk_dec_len
  logic op_take;
  assign op_take = state_r == mbd_pkg::MBD_ST_FETCH && i_code_valid && o_code_req;

  chk_icyc_four: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    icyc_end |=> !icyc_end [*3] ##1 icyc_end) else $error("instruction cycle not four clocks");

  chk_xdata_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_r == mbd_pkg::MBD_ST_FETCH && i_code_valid && o_code_req &&
     f_is_xdata(i_code_data)) |=> o_len_cycles == 4'h2 + {1'b0, $past(stretch_r[2:0])})
    else $error("external move cycle count wrong");

  chk_far_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_r == mbd_pkg::MBD_ST_FETCH && i_code_valid && o_code_req &&
     i_code_data == mbd_pkg::OP_FAR_JUMP) |=> o_len_bytes == 2'h3 && o_len_cycles == 4'h4)
    else $error("far jump length wrong");

  chk_nop_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_r == mbd_pkg::MBD_ST_FETCH && i_code_valid && o_code_req &&
     i_code_data == mbd_pkg::OP_NOP_RSVD) |=> o_class == 3'b101 && o_len_cycles == 4'h1)
    else $error("reserved opcode not a no-operation");

  chk_ptr_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_r == mbd_pkg::MBD_ST_FETCH && i_code_valid && o_code_req) |=>
    o_use_ptr1 == $past(ptr_sel_r)) else $error("pointer select not captured");

  chk_no_early_fetch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state_r == mbd_pkg::MBD_ST_EXEC) |-> !o_code_req) else $error("fetch during execute");

  chk_bit_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data == mbd_pkg::OP_CLR_BIT || i_code_data == mbd_pkg::OP_SET_BIT ||
     i_code_data == mbd_pkg::OP_CPL_BIT))
    |=> o_len_bytes == 2'h2 && o_len_cycles == 4'h2)
    else $error("bit operation length wrong");

  chk_and_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data == mbd_pkg::OP_AND_C_BIT || i_code_data == mbd_pkg::OP_AND_C_NBIT))
    |=> o_len_bytes == 2'h2 && o_len_cycles == 4'h2)
    else $error("carry AND length wrong");

  chk_ptr_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && i_code_data == mbd_pkg::OP_LOAD_PTR)
    |=> o_len_bytes == 2'h3 && o_len_cycles == 4'h3)
    else $error("pointer load length wrong");

  chk_code_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data == mbd_pkg::OP_CODE_RD_PTR || i_code_data == mbd_pkg::OP_CODE_RD_PC))
    |=> o_len_bytes == 2'h1 && o_len_cycles == 4'h3)
    else $error("code byte read length wrong");

  chk_xdata_form: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && f_is_xdata(i_code_data))
    |=> o_len_bytes == 2'h1 && o_class == 3'b011)
    else $error("external move form wrong");

  chk_exch_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data[7:3] == mbd_pkg::OP_XCH_REG || i_code_data[7:1] == mbd_pkg::OP_XCH_IND ||
     i_code_data[7:1] == mbd_pkg::OP_NIBBLE_XCH))
    |=> o_len_bytes == 2'h1 && o_len_cycles == 4'h1 && o_class == 3'b010)
    else $error("exchange length wrong");

  chk_page_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data[4:0] == mbd_pkg::OP_PAGE_JUMP_LO ||
     i_code_data[4:0] == mbd_pkg::OP_PAGE_CALL_LO))
    |=> o_len_bytes == 2'h2 && o_len_cycles == 4'h3 && o_class == 3'b100)
    else $error("page branch length wrong");

  chk_return_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data == mbd_pkg::OP_RETURN || i_code_data == mbd_pkg::OP_INT_RETURN))
    |=> o_len_bytes == 2'h1 && o_len_cycles == 4'h4 && o_class == 3'b100)
    else $error("return length wrong");

  chk_rel_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data == mbd_pkg::OP_NEAR_JUMP || i_code_data == mbd_pkg::OP_JUMP_C ||
     i_code_data == mbd_pkg::OP_JUMP_NC))
    |=> o_len_bytes == 2'h2 && o_len_cycles == 4'h3)
    else $error("relative jump length wrong");

  chk_bit_jump: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data == mbd_pkg::OP_JUMP_BIT || i_code_data == mbd_pkg::OP_JUMP_NBIT ||
     i_code_data == mbd_pkg::OP_JUMP_BIT_CLR))
    |=> o_len_bytes == 2'h3 && o_len_cycles == 4'h4)
    else $error("bit test jump length wrong");

  chk_cmp_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && (i_code_data == mbd_pkg::OP_CMP_A_DIR || i_code_data == mbd_pkg::OP_CMP_A_IMM ||
     i_code_data[7:3] == mbd_pkg::OP_CMP_REG || i_code_data[7:1] == mbd_pkg::OP_CMP_IND))
    |=> o_len_bytes == 2'h3 && o_len_cycles == 4'h4)
    else $error("compare jump length wrong");

  chk_dec_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (op_take && i_code_data[7:3] == mbd_pkg::OP_DEC_REG)
    |=> o_len_bytes == 2'h2 && o_len_cycles == 4'h3)
    else $error("register decrement jump length wrong");

  chk_done_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_instr_done |=> !o_instr_done && o_code_req)
    else $error("done not a single pulse before next fetch");

endmodule // mbd_decode

`default_nettype wire

/* sim/mbd_code_mem.sv */
// Program memory model that serves code bytes to the decode block
`timescale 1ns/1ns
`default_nettype none
module mbd_code_mem (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_code_req,
  output logic [7:0] o_code_data,
  output logic o_code_valid
);
  // ==========================================
  // Byte store, loaded by the bench one instruction at a time
  logic [7:0] mem_r [4];
  int rd_ptr = 0;
  int end_ptr = 0;
  logic take_r = 1'b0;
  initial begin
    o_code_data = 8'h00;
    o_code_valid = 1'b0;
  end
  // ==========================================
  // A byte counts as taken only on an edge with request and valid both high
  always @(posedge i_mclk) begin
    take_r <= o_code_valid && i_code_req && i_rst_n;
  end
  // Past the loaded bytes the bus toggles so stale data never looks valid
  always @(negedge i_mclk) begin
    if (take_r) begin
      rd_ptr = rd_ptr + 1;
    end
    if (rd_ptr < end_ptr) begin
      o_code_data = mem_r[rd_ptr];
      o_code_valid = 1'b1;
    end else begin
      o_code_data = ~o_code_data;
      o_code_valid = 1'b0;
    end
  end
endmodule // mbd_code_mem
`default_nettype wire

/* sim/mbd_decode_tb.sv */
// Self-checking bench for the decode and timing block
`timescale 1ns/1ns
`default_nettype none
module mbd_decode_tb;
  // ==========================================
  // Clock, stimulus and design
  logic i_mclk = 1'b0;
  logic i_rst_n;
  logic [7:0] i_code_data;
  logic i_code_valid;
  logic i_sfr_wr;
  logic [7:0] i_sfr_addr;
  logic [7:0] i_sfr_wdata;
  logic [7:0] o_sfr_rdata;
  logic o_code_req;
  logic [7:0] o_opcode;
  logic [1:0] o_len_bytes;
  logic [3:0] o_len_cycles;
  logic [2:0] o_class;
  logic o_use_ptr1;
  logic o_xdata_wr;
  logic o_busy;
  logic o_instr_done;
  int err_total = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  logic [7:0] rd;
  // Entry: opcode, byte length, instruction cycles
  logic [15:0] tbl [50] = '{
    16'hC311, 16'hC222, 16'hD311, 16'hD222, 16'hB311, 16'hB222, 16'h8222, 16'hB022,
    16'h7222, 16'hA022, 16'hA222, 16'h9222, 16'h9033, 16'h9313, 16'h8313, 16'h8533,
    16'h7533, 16'hC022, 16'hD022, 16'hC811, 16'hCF11, 16'hC611, 16'hD711, 16'h1123,
    16'hF123, 16'h0123, 16'hE123, 16'h1234, 16'h0234, 16'h2214, 16'h3214, 16'h8023,
    16'h4023, 16'h5023, 16'h2034, 16'h3034, 16'h1034, 16'h7313, 16'h6023, 16'h7023,
    16'hB534, 16'hB434, 16'hB834, 16'hBF34, 16'hB634, 16'hD823, 16'hDF23, 16'hD534,
    16'h0011, 16'hA511};
  logic [7:0] xops [4] = '{8'hE0, 8'hF2, 8'hE3, 8'hF0};
  always #(mbd_pkg::CLK_PERIOD_NS / 2) i_mclk = ~i_mclk;
  mbd_decode dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_code_data(i_code_data),
    .i_code_valid(i_code_valid), .i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_code_req(o_code_req),
    .o_opcode(o_opcode), .o_len_bytes(o_len_bytes), .o_len_cycles(o_len_cycles),
    .o_class(o_class), .o_use_ptr1(o_use_ptr1), .o_xdata_wr(o_xdata_wr), .o_busy(o_busy),
    .o_instr_done(o_instr_done));
  mbd_code_mem mem_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_code_req(o_code_req),
    .o_code_data(i_code_data), .o_code_valid(i_code_valid));
  // ==========================================
  // Shared tasks
  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_sfr_wr = 1'b1;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    @(negedge i_mclk);
    i_sfr_wr = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    i_sfr_addr = a;
    @(negedge i_mclk);
    d = o_sfr_rdata;
  endtask
  // Loads one instruction, waits for completion, checks length, timing and fetch count
  task automatic run_op(input logic [15:0] e);
    int n;
    int k;
    @(posedge i_mclk);
    #1;
    mem_u.mem_r[0] = e[15:8];
    for (k = 1; k < 4; k++) begin
      mem_u.mem_r[k] = 8'(k * 37);
    end
    mem_u.rd_ptr = 0;
    mem_u.end_ptr = int'(e[7:4]);
    n = 0;
    while (o_instr_done !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk(16'(o_opcode), 16'(e[15:8]));
    chk(16'(o_len_bytes), 16'(e[7:4]));
    chk(16'(o_len_cycles), 16'(e[3:0]));
    chk(16'(mem_u.rd_ptr), 16'(e[7:4]));
    // Divider phase may trim the first cycle, request restart may add up to one cycle
    chk(16'(n >= (int'(e[3:0]) - 1) * 4 && n <= int'(e[3:0]) * 4 + 4), 16'h0001);
    chk(16'(o_busy), 16'h0001);
    // Done lasts one clock; one clock later the block is idle and asking again
    @(posedge i_mclk);
    #1;
    chk(16'(o_instr_done), 16'h0000);
    chk(16'(o_busy), 16'h0000);
    chk(16'(o_code_req), 16'h0001);
  endtask
  // ==========================================
  // Hang guard
  always @(posedge i_mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    i_sfr_wr = 1'b0;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    repeat (20) @(negedge i_mclk);
    i_rst_n = 1'b1;
    sfr_rd(mbd_pkg::SFR_STRETCH, rd);
    chk(16'(rd), 16'h0001);
    sfr_rd(8'h80, rd);
    chk(16'(rd), 16'h0000);
    sfr_rd(mbd_pkg::SFR_PTR_SEL, rd);
    chk(16'(rd), 16'h0000);
    run_op(16'hE013);
    for (int i = 0; i < 50; i++) begin
      run_op(tbl[i]);
    end // Same loop
    chk(16'(o_class), 16'h0005);
    // Every stretch value, read and write forms, both address kinds
    for (int v = 0; v < 8; v++) begin
      sfr_wr(mbd_pkg::SFR_STRETCH, 8'(v));
      sfr_rd(mbd_pkg::SFR_STRETCH, rd);
      chk(16'(rd), 16'(v));
      run_op({xops[v % 4], 4'h1, 4'(v + 2)});
      chk(16'(o_xdata_wr), 16'(xops[v % 4][4]));
      chk(16'(o_class), 16'h0003);
    end
    sfr_wr(mbd_pkg::SFR_PTR_SEL, 8'hFF);
    sfr_rd(mbd_pkg::SFR_PTR_SEL, rd);
    chk(16'(rd), 16'h0001);
    run_op(16'h9033);
    chk(16'(o_class), 16'h0000);
    chk(16'(o_use_ptr1), 16'h0001);
    sfr_wr(mbd_pkg::SFR_PTR_SEL, 8'h00);
    run_op(16'h7313);
    chk(16'(o_use_ptr1), 16'h0000);
    chk(16'(o_class), 16'h0004);
    run_op(16'hD711);
    chk(16'(o_class), 16'h0002);
    end_of_test();
  end
endmodule // mbd_decode_tb
`default_nettype wire
